// ---- core/tbs_pkg.sv ----
package tbs_pkg;

   // register byte offsets
   localparam logic [7:0] OFF_STATUS_WORD = 8'h00;   // bus_health_status_word, read only
   localparam logic [7:0] OFF_CONTROL     = 8'h04;   // control: bit0 reset request, bit1 startup capture
   localparam logic [7:0] OFF_IRQ_STATUS  = 8'h08;   // sticky events, write one to clear
   localparam logic [7:0] OFF_IRQ_MASK    = 8'h0c;   // interrupt enables
   localparam logic [7:0] OFF_CFG_IMAGE   = 8'h10;   // configured process image lengths
   localparam logic [7:0] OFF_CYCLE_TIME  = 8'h14;   // last bus cycle length in cycles

   // status word bit positions
   localparam int BIT_BUS_ERR     = 0;
   localparam int BIT_CFG_CHANGED = 1;
   localparam int BIT_LEN_MISMAT  = 2;
   localparam int BIT_NO_INPUTS   = 8;
   localparam int BIT_IN_BUSY     = 9;
   localparam int BIT_OUT_BUSY    = 10;
   localparam int BIT_WATCHDOG    = 11;
   localparam int BIT_ACYCLIC     = 15;

   // control bit positions
   localparam int CTL_RESET_REQ = 0;
   localparam int CTL_CAPTURE   = 1;

   // interrupt event bit positions
   localparam int EV_BUS_ERR   = 0;
   localparam int EV_CFG_CHG   = 1;
   localparam int EV_LEN_MIS   = 2;
   localparam int EV_WATCHDOG  = 3;
   localparam int EV_CYCLE_END = 4;
   localparam int EV_OVERRUN   = 5;
   localparam int EV_WIDTH     = 6;

   // reset values
   localparam logic [15:0] RST_STATUS   = 16'h0100;   // no valid inputs yet
   localparam logic [31:0] RST_CFG_IMG  = 32'h0000_0000;
   localparam logic [5:0]  RST_MASK     = 6'h00;

   // timing
   localparam int CLK_HZ           = 25_000_000;
   localparam int UPDATE_TYP_MS    = 5;                       // typical longest bus update
   localparam int UPDATE_TYP_CYC   = CLK_HZ / 1000 * UPDATE_TYP_MS;

   // terminal bus engine report
   typedef struct packed {
      logic        bus_error;      // pulse
      logic [15:0] cfg_signature;  // level, current terminal configuration
      logic [15:0] in_len;         // level, actual input image length
      logic [15:0] out_len;        // level, actual output image length
      logic        in_busy;        // level
      logic        out_busy;       // level
      logic        inputs_valid;   // pulse, valid input data obtained
      logic        watchdog_trip;  // pulse
      logic        acyclic_active; // level
   } tbs_bus_report_type;

   // task side
   typedef struct packed {
      logic task_tick;             // pulse at each controlling task start
   } tbs_task_type;

endpackage : tbs_pkg

// ---- core/tbs_bus_sync.sv ----
`timescale 1ns/10ps
// double flop synchroniser for asynchronous levels
module tbs_bus_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // first stage feeds only the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule : tbs_bus_sync

// ---- core/tbs_status_word.sv ----
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
// Operation
// - bit 0 sets on bus error and holds until a reset request clears it
// - bit 1 sets when terminal configuration differs from the startup one
// - bit 2 sets when configured and actual image lengths differ
// - bit 8 set until valid input data has been obtained, also after startup
// - bit 9 set while input update runs, and held to the next task tick when an update was still running at the last one
// - bit 10 set while output update runs, cleared when done
// - bit 11 set when bus watchdog trips
// - bit 15 set while an acyclic bus function such as reset executes
// - word is zero only for error free, task synchronous operation
// - cycle longer than task period makes the word nonzero
// - bus update completes typically within one to five ms
module tbs_status_word #(
   parameter int UPDATE_LIMIT = tbs_pkg::UPDATE_TYP_CYC
) (
   // clock and reset
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   // ahb-lite slave
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic      [31:0]                 hrdata,
   output logic                             hreadyout,
   output logic                             hresp,
   // terminal bus engine, asynchronous to hclk
   input  wire tbs_pkg::tbs_bus_report_type bus_report,
   // controlling task, same clock
   input  wire tbs_pkg::tbs_task_type       task_in,
   // status word to task software and interrupt
   output logic      [15:0]                 status_word,
   output logic                             bus_reset_req,
   output logic                             irq
);

   localparam int RPT_W = $bits(tbs_pkg::tbs_bus_report_type);

   tbs_pkg::tbs_bus_report_type rpt;
   logic [RPT_W-1:0]            rpt_bits;

   // bring engine report into hclk domain
   tbs_bus_sync #(
      .WIDTH    (RPT_W)
   ) u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (bus_report),
      .sync_out (rpt_bits)
   );
   assign rpt = tbs_pkg::tbs_bus_report_type'(rpt_bits);

   // edge detect pulses after synchronisation
   logic err_d_reg, valid_d_reg, wd_d_reg;
   logic err_ev, valid_ev, wd_ev;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_d_reg   <= 1'b0;
         valid_d_reg <= 1'b0;
         wd_d_reg    <= 1'b0;
      end else begin
         err_d_reg   <= rpt.bus_error;
         valid_d_reg <= rpt.inputs_valid;
         wd_d_reg    <= rpt.watchdog_trip;
      end
   end
   assign err_ev   = rpt.bus_error & ~err_d_reg;
   assign valid_ev = rpt.inputs_valid & ~valid_d_reg;
   assign wd_ev    = rpt.watchdog_trip & ~wd_d_reg;

   // ahb address phase capture
   logic        wr_pend_reg;
   logic        rd_pend_reg;
   logic [7:0]  addr_reg;
   logic        take;
   assign take = hsel & hready & htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
      end else begin
         wr_pend_reg <= take & hwrite;
         rd_pend_reg <= take & ~hwrite;
         if (take) begin
            addr_reg <= haddr[7:0];
         end
      end
   end
   assign hreadyout = 1'b1;   // zero wait states
   assign hresp     = 1'b0;   // always okay

   function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] off);
      wr_hit = pend && (a == off);
   endfunction : wr_hit

   logic wr_ctl, wr_irq_st, wr_mask, wr_cfg;
   assign wr_ctl    = wr_hit(wr_pend_reg, addr_reg, tbs_pkg::OFF_CONTROL);
   assign wr_irq_st = wr_hit(wr_pend_reg, addr_reg, tbs_pkg::OFF_IRQ_STATUS);
   assign wr_mask   = wr_hit(wr_pend_reg, addr_reg, tbs_pkg::OFF_IRQ_MASK);
   assign wr_cfg    = wr_hit(wr_pend_reg, addr_reg, tbs_pkg::OFF_CFG_IMAGE);

   // control writes: reset request pulse and startup capture pulse
   logic reset_req, capture_req;
   assign reset_req   = wr_ctl & hwdata[tbs_pkg::CTL_RESET_REQ];
   assign capture_req = wr_ctl & hwdata[tbs_pkg::CTL_CAPTURE];
   assign bus_reset_req = reset_req;

   // configured image lengths
   logic [31:0] cfg_image_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_image_reg <= tbs_pkg::RST_CFG_IMG;
      end else if (wr_cfg) begin
         cfg_image_reg <= hwdata;
      end
   end

   // startup configuration snapshot taken on first valid inputs pulse or capture
   logic [15:0] start_sig_reg;
   logic        start_valid_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         start_sig_reg   <= 16'h0000;
         start_valid_reg <= 1'b0;
      end else if (capture_req || (!start_valid_reg && valid_ev)) begin
         start_sig_reg   <= rpt.cfg_signature;
         start_valid_reg <= 1'b1;
      end
   end

   // bus error sticky until reset request, set wins
   logic bus_err_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_err_reg <= 1'b0;
      end else if (err_ev) begin
         bus_err_reg <= 1'b1;
      end else if (reset_req) begin
         bus_err_reg <= 1'b0;
      end
   end

   // watchdog flag, held until reset request
   logic wd_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wd_reg <= 1'b0;
      end else if (wd_ev) begin
         wd_reg <= 1'b1;
      end else if (reset_req) begin
         wd_reg <= 1'b0;
      end
   end

   // valid inputs seen; lost on reset request
   logic valid_seen_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         valid_seen_reg <= 1'b0;
      end else if (valid_ev) begin
         valid_seen_reg <= 1'b1;
      end else if (reset_req) begin
         valid_seen_reg <= 1'b0;
      end
   end

   // task synchronism: a busy update still running at the next task tick
   logic busy_any;
   logic overrun_reg;
   logic [31:0] cyc_cnt_reg;
   logic [31:0] cyc_last_reg;
   logic        busy_d_reg;
   logic        slow_ev;
   assign busy_any = rpt.in_busy | rpt.out_busy;
   assign slow_ev  = busy_any && (cyc_cnt_reg == 32'(UPDATE_LIMIT));
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         overrun_reg <= 1'b0;
      end else if (task_in.task_tick) begin
         overrun_reg <= busy_any;
      end
   end

   // cycle length measure, also flags updates beyond typical time
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cyc_cnt_reg  <= 32'h0000_0000;
         cyc_last_reg <= 32'h0000_0000;
         busy_d_reg   <= 1'b0;
      end else begin
         busy_d_reg <= busy_any;
         if (busy_any && !busy_d_reg) begin
            cyc_cnt_reg <= 32'h0000_0001;
         end else if (busy_any && cyc_cnt_reg != 32'hffff_ffff) begin
            cyc_cnt_reg <= cyc_cnt_reg + 32'h0000_0001;
         end
         if (!busy_any && busy_d_reg) begin
            cyc_last_reg <= cyc_cnt_reg;
         end
      end
   end

   // assemble status word; bit 10 follows the engine level, bit 9 also holds the overrun flag
   logic [15:0] word;
   logic        cfg_chg, len_mis;
   always_comb begin
      cfg_chg = start_valid_reg && (rpt.cfg_signature != start_sig_reg);
      len_mis = ({rpt.out_len, rpt.in_len} != cfg_image_reg);
      word    = 16'h0000;
      word[tbs_pkg::BIT_BUS_ERR]     = bus_err_reg;
      word[tbs_pkg::BIT_CFG_CHANGED] = cfg_chg;
      word[tbs_pkg::BIT_LEN_MISMAT]  = len_mis;
      word[tbs_pkg::BIT_NO_INPUTS]   = ~valid_seen_reg;
      word[tbs_pkg::BIT_IN_BUSY]     = rpt.in_busy | overrun_reg;
      word[tbs_pkg::BIT_OUT_BUSY]    = rpt.out_busy;
      word[tbs_pkg::BIT_WATCHDOG]    = wd_reg;
      word[tbs_pkg::BIT_ACYCLIC]     = rpt.acyclic_active;
   end

   // registered status word; zero only if all conditions clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_word <= tbs_pkg::RST_STATUS;
      end else begin
         status_word <= word;
      end
   end

   // interrupt events
   logic [tbs_pkg::EV_WIDTH-1:0] ev;
   logic [tbs_pkg::EV_WIDTH-1:0] irq_st_reg;
   logic [tbs_pkg::EV_WIDTH-1:0] irq_mask_reg;
   logic                         cfg_chg_d_reg, len_mis_d_reg, overrun_d_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_chg_d_reg <= 1'b0;
         len_mis_d_reg <= 1'b0;
         overrun_d_reg <= 1'b0;
      end else begin
         cfg_chg_d_reg <= cfg_chg;
         len_mis_d_reg <= len_mis;
         overrun_d_reg <= overrun_reg;
      end
   end
   always_comb begin
      ev = '0;
      ev[tbs_pkg::EV_BUS_ERR]   = err_ev;
      ev[tbs_pkg::EV_CFG_CHG]   = cfg_chg & ~cfg_chg_d_reg;
      ev[tbs_pkg::EV_LEN_MIS]   = len_mis & ~len_mis_d_reg;
      ev[tbs_pkg::EV_WATCHDOG]  = wd_ev;
      ev[tbs_pkg::EV_CYCLE_END] = ~busy_any & busy_d_reg;
      ev[tbs_pkg::EV_OVERRUN]   = (overrun_reg & ~overrun_d_reg) | slow_ev;
   end

   // sticky status, write one clears, set wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_st_reg <= '0;
      end else begin
         irq_st_reg <= (irq_st_reg & ~(wr_irq_st ? hwdata[tbs_pkg::EV_WIDTH-1:0] : '0)) | ev;
      end
   end

   // interrupt mask
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask_reg <= tbs_pkg::RST_MASK;
      end else if (wr_mask) begin
         irq_mask_reg <= hwdata[tbs_pkg::EV_WIDTH-1:0];
      end
   end
   assign irq = |(irq_st_reg & irq_mask_reg);

   // read data, unmapped reads zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         case (haddr[7:0])
            tbs_pkg::OFF_STATUS_WORD: hrdata <= {16'h0000, word};
            tbs_pkg::OFF_CONTROL:     hrdata <= 32'h0000_0000;
            tbs_pkg::OFF_IRQ_STATUS:  hrdata <= {26'h0, irq_st_reg};
            tbs_pkg::OFF_IRQ_MASK:    hrdata <= {26'h0, irq_mask_reg};
            tbs_pkg::OFF_CFG_IMAGE:   hrdata <= cfg_image_reg;
            tbs_pkg::OFF_CYCLE_TIME:  hrdata <= cyc_last_reg;
            default:                  hrdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule : tbs_status_word

// ---- testbench/tbs_checker.sv ----
`timescale 1ns/10ps
// watches the status word against its causes on the ports
module tbs_checker (
   // clock and reset
   input wire logic                        hclk,
   input wire logic                        hresetn,
   // register bus
   input wire logic                        hsel,
   input wire logic [31:0]                 haddr,
   input wire logic [1:0]                  htrans,
   input wire logic                        hwrite,
   input wire logic [31:0]                 hwdata,
   input wire logic                        hready,
   // engine report and results
   input wire tbs_pkg::tbs_bus_report_type bus_report,
   input wire logic [15:0]                 status_word,
   input wire logic                        bus_reset_req
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // error bit follows an error pulse within the sync delay
   property p_err_set;
      $rose(bus_report.bus_error) |-> ##[1:6] status_word[0];
   endproperty
   a_err_set: assert property (p_err_set) else $error("error bit not set");
   // error bit only drops after a reset request
   property p_err_hold;
      $fell(status_word[0]) |-> $past(bus_reset_req) || $past(bus_reset_req, 2) || $past(bus_reset_req, 3);
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error bit dropped alone");
   // reset request pulse only in the data phase of a control write of one
   property p_req;
      bus_reset_req |-> $past(hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h04) && hwdata[0];
   endproperty
   a_req: assert property (p_req) else $error("stray reset request");
   // reset request brings back the no valid inputs bit
   property p_noin;
      bus_reset_req && !bus_report.inputs_valid |-> ##[1:3] status_word[8];
   endproperty
   a_noin: assert property (p_noin) else $error("no inputs bit not set");
   // input busy level shows in bit 9
   property p_in;
      bus_report.in_busy [*6] |-> status_word[9];
   endproperty
   a_in: assert property (p_in) else $error("input busy bit missing");
   // output busy level shows in bit 10 and leaves with it
   property p_out;
      bus_report.out_busy [*6] |-> status_word[10];
   endproperty
   a_out: assert property (p_out) else $error("output busy bit missing");
   property p_out_clr;
      !bus_report.out_busy [*6] |-> !status_word[10];
   endproperty
   a_out_clr: assert property (p_out_clr) else $error("output busy bit stuck");
   // watchdog trip sets bit 11
   property p_wd;
      $rose(bus_report.watchdog_trip) |-> ##[1:6] status_word[11];
   endproperty
   a_wd: assert property (p_wd) else $error("watchdog bit not set");
   // acyclic function level shows in bit 15
   property p_acy;
      bus_report.acyclic_active [*6] |-> status_word[15];
   endproperty
   a_acy: assert property (p_acy) else $error("acyclic bit missing");
   // undefined bits stay zero
   property p_undef;
      status_word[7:3] == 5'h00 && status_word[14:12] == 3'h0;
   endproperty
   a_undef: assert property (p_undef) else $error("undefined bits set");
endmodule : tbs_checker

bind tbs_status_word tbs_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .bus_report(bus_report),
   .status_word(status_word), .bus_reset_req(bus_reset_req));

// ---- testbench/tbs_chain_model.sv ----
`timescale 1ns/10ps
// terminal chain stand-in: busy periods, event pulses and levels
module tbs_chain_model (
   // clock
   input  wire logic                   hclk,
   // cycle request and busy length in cycles
   input  wire logic                   cycle_go,
   input  wire logic [7:0]             busy_len,
   // report toward the block
   output tbs_pkg::tbs_bus_report_type bus_report
);
   logic [7:0] busy_cnt;

   // idle chain with a fixed configuration
   initial begin
      busy_cnt = 8'h00;
      bus_report = '0;
      bus_report.cfg_signature = 16'h00a5;
      bus_report.in_len = 16'h0010;
      bus_report.out_len = 16'h0008;
   end

   // input and output updates run while the count is live
   always @(posedge hclk) begin
      if (cycle_go) begin
         busy_cnt <= busy_len;
      end else if (busy_cnt != 8'h00) begin
         busy_cnt <= busy_cnt - 8'h01;
      end
      bus_report.in_busy <= busy_cnt > 8'h00;
      bus_report.out_busy <= busy_cnt > 8'h00;
   end

   // event pulse held three cycles, then low three
   task automatic pulse(input logic [2:0] sel);
      @(posedge hclk);
      {bus_report.bus_error, bus_report.watchdog_trip, bus_report.inputs_valid} <= sel;
      repeat (3) @(posedge hclk);
      {bus_report.bus_error, bus_report.watchdog_trip, bus_report.inputs_valid} <= 3'b000;
      repeat (3) @(posedge hclk);
   endtask : pulse

   // configuration, input and output lengths and acyclic activity
   task automatic levels(input logic [15:0] sig, input logic [15:0] len, input logic [15:0] olen, input logic acy);
      @(posedge hclk);
      bus_report.cfg_signature <= sig;
      bus_report.in_len <= len;
      bus_report.out_len <= olen;
      bus_report.acyclic_active <= acy;
   endtask : levels
endmodule : tbs_chain_model

// ---- testbench/tbs_status_word_tb.sv ----
`timescale 1ns/10ps
module tbs_status_word_tb;
   logic                        hclk;
   logic                        hresetn;
   logic                        hsel;
   logic [31:0]                 haddr;
   logic [1:0]                  htrans;
   logic                        hwrite;
   logic [2:0]                  hsize;
   logic [31:0]                 hwdata;
   logic [31:0]                 hrdata;
   logic                        hreadyout;
   logic                        hresp;
   logic [15:0]                 status_word;
   logic                        bus_reset_req;
   logic                        irq;
   logic                        cycle_go;
   logic [7:0]                  busy_len;
   logic [31:0]                 rd;
   int                          mismatches;
   int                          samples_checked;
   tbs_pkg::tbs_task_type       task_in;
   tbs_pkg::tbs_bus_report_type bus_report;

   tbs_status_word #(.UPDATE_LIMIT(50)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .bus_report(bus_report), .task_in(task_in),
      .status_word(status_word), .bus_reset_req(bus_reset_req), .irq(irq));
   tbs_chain_model u_chain (.hclk(hclk), .cycle_go(cycle_go), .busy_len(busy_len), .bus_report(bus_report));

   // 25 MHz clock
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   task automatic results;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         mismatches++;
      end
   endtask : chk

   // one single transfer: address phase, then data phase
   task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      ahb(a, 1'b1, d);
   endtask : wr

   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      ahb(a, 1'b0, 32'h0000_0000);
      chk(rd, e);
      chk({31'h0, hresp}, 32'h0000_0000);
   endtask : rdc

   // outputs are looked at half a cycle after the edge, once settled
   task automatic st(input logic [15:0] e);
      @(negedge hclk);
      chk({16'h0000, status_word}, {16'h0000, e});
   endtask : st

   task automatic sb(input int b, input logic e);
      @(negedge hclk);
      chk({31'h0, status_word[b]}, {31'h0, e});
   endtask : sb

   task automatic ck_irq(input logic e);
      @(negedge hclk);
      chk({31'h0, irq}, {31'h0, e});
   endtask : ck_irq

   task automatic w(input int n);
      repeat (n) @(posedge hclk);
   endtask : w

   // task tick, optionally starting a bus cycle of n busy cycles
   task automatic cyc(input logic [7:0] n, input logic go);
      @(posedge hclk);
      task_in.task_tick <= 1'b1;
      cycle_go <= go;
      busy_len <= n;
      @(posedge hclk);
      task_in.task_tick <= 1'b0;
      cycle_go <= 1'b0;
   endtask : cyc

   // lengths matched, inputs valid, one clean cycle
   task automatic t_sync;
      w(8);
      sb(2, 1'b1);
      sb(8, 1'b1);
      wr(32'h10, 32'h0008_0010);
      rdc(32'h10, 32'h0008_0010);
      u_chain.pulse(3'b001);
      w(4);
      st(16'h0000);
      cyc(8'd12, 1'b1);
      w(6);
      st(16'h0600);
      w(16);
      st(16'h0000);
   endtask : t_sync

   // cycle longer than the task period and the update limit
   task automatic t_over;
      wr(32'h08, 32'h3f);
      wr(32'h0c, 32'h20);
      rdc(32'h0c, 32'h20);
      cyc(8'd80, 1'b1);
      w(20);
      cyc(8'd0, 1'b0);
      w(70);
      sb(9, 1'b1);
      ck_irq(1'b1);
      rdc(32'h08, 32'h30);
      rdc(32'h14, 32'h50);
      wr(32'h08, 32'h3f);
      ck_irq(1'b0);
      cyc(8'd0, 1'b0);
      w(6);
      st(16'h0000);
      // a long cycle with no tick inside flags only the update limit
      cyc(8'd60, 1'b1);
      w(70);
      rdc(32'h08, 32'h30);
   endtask : t_over

   // sticky error, cleared only by a reset request
   task automatic t_err;
      wr(32'h0c, 32'h01);
      u_chain.pulse(3'b100);
      st(16'h0001);
      ck_irq(1'b1);
      w(30);
      wr(32'h08, 32'h01);
      st(16'h0001);
      ck_irq(1'b0);
      wr(32'h04, 32'h01);
      w(3);
      st(16'h0100);
      u_chain.pulse(3'b001);
      st(16'h0000);
   endtask : t_err

   // configuration, lengths, watchdog, acyclic, map
   task automatic t_misc;
      u_chain.levels(16'h005a, 16'h0010, 16'h0008, 1'b0);
      w(6);
      st(16'h0002);
      wr(32'h04, 32'h02);
      w(3);
      st(16'h0000);
      u_chain.levels(16'h00a5, 16'h0010, 16'h0008, 1'b0);
      w(6);
      st(16'h0002);
      wr(32'h04, 32'h02);
      w(3);
      st(16'h0000);
      u_chain.levels(16'h00a5, 16'h0011, 16'h0008, 1'b1);
      w(6);
      st(16'h8004);
      u_chain.levels(16'h00a5, 16'h0010, 16'h0009, 1'b0);
      w(6);
      st(16'h0004);
      u_chain.levels(16'h00a5, 16'h0010, 16'h0008, 1'b0);
      u_chain.pulse(3'b010);
      st(16'h0800);
      rdc(32'h00, 32'h0000_0800);
      rdc(32'h40, 32'h0000_0000);
      wr(32'h04, 32'h01);
      u_chain.pulse(3'b001);
      st(16'h0000);
   endtask : t_misc

   // reset, then the scenarios
   initial begin
      mismatches = 0;
      samples_checked = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      task_in = '0;
      cycle_go = 1'b0;
      busy_len = 8'h00;
      rd = 32'h0000_0000;
      repeat (18) @(posedge hclk);
      st(16'h0100);
      ck_irq(1'b0);
      @(posedge hclk);
      hresetn <= 1'b1;
      t_sync;
      t_over;
      t_err;
      t_misc;
      results;
   end

   // hang guard
   initial begin
      #400000;
      mismatches++;
      results;
   end
endmodule : tbs_status_word_tb
